// ### bench/pcd_analog_src.sv
`timescale 1ns/1ps
// Analog sources on the port 3 comparator pins
module pcd_analog_src (
   input wire logic clk,
   input wire logic signed [31:0] va,
   input wire logic signed [31:0] vb,
   input wire logic signed [31:0] vref,
   input wire logic enable,
   output logic a_out,
   output logic b_out
);
   initial begin
      a_out = 1'b0;
      b_out = 1'b0;
   end
   // Disabled comparators give no valid level, so keep them moving
   always @(negedge clk) begin
      if (enable) begin
         a_out <= (va > vref);
         b_out <= (vb > vref);
      end else begin
         a_out <= ~a_out;
         b_out <= ~b_out;
      end
   end
endmodule : pcd_analog_src

// ### bench/port_comparator_and_drain_control_tb_top.sv
`timescale 1ns/1ps
module port_comparator_and_drain_control_tb_top;
   logic clk, srst, sr_rst, chk, clr, ca, cb, cen, am, irq_a, irq_b, tm, so, xi;
   pcd_pkg::pcd_power_e pwr;
   pcd_pkg::pcd_wr_s wr;
   pcd_pkg::pcd_drive_s drive;
   logic [1:0] sel, na, nb, nx;
   logic [7:0] pins_in, st, rd, pout;
   int va, vb, vr, miscompares, checks_done;
   logic [45:0] q[$];
   logic [45:0] e;
   logic [22:0] obs;
   assign obs = {nx, tm, so, na, nb, cen, drive, am, rd[2:1], pout};
   pcd_analog_src pcd_analog_src_inst (.clk(clk), .va(va), .vb(vb), .vref(vr), .enable(cen),
      .a_out(ca), .b_out(cb));
   pcd_ctrl pcd_ctrl_inst (.clk(clk), .srst(srst), .stop_recovery_rst(sr_rst), .power_state(pwr),
      .wr(wr), .irq_edge_sel(sel), .cmp_a_raw(ca), .cmp_b_raw(cb), .p3_pins_in(pins_in),
      .p3_out_stored(st), .p3_read(rd), .p3_pins_out(pout), .cmp_enable(cen),
      .analog_mode(am), .timer_in(tm), .irq_cmp_a(irq_a), .irq_cmp_b(irq_b),
      .external_interrupt_one(xi), .stop_sense_ok(so), .drive(drive));
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   task automatic wr_reg(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= '{1'b1, b, a, d};
      @(posedge clk);
      wr.we <= 1'b0;
   endtask : wr_reg
   task automatic exp(input logic [22:0] m, input logic [22:0] v);
      @(posedge clk);
      q.push_back({m, v});
      chk <= 1'b1;
      @(posedge clk);
      chk <= 1'b0;
   endtask : exp
   // Edges are counted from a cleared start so settling glitches are not charged
   task automatic irq_case(input logic [1:0] s, input int a0, a1, b0, b1, input logic [22:0] v);
      clr <= 1'b1;
      sel <= s;
      repeat (8) @(posedge clk);
      clr <= 1'b0;
      va <= a1;
      vb <= b1;
      pins_in[3] <= ~pins_in[3];
      repeat (8) @(posedge clk);
      va <= a0;
      vb <= b0;
      pins_in[3] <= ~pins_in[3];
      repeat (8) @(posedge clk);
      exp(23'h678000, v);
   endtask : irq_case
   always @(posedge clk) begin
      na <= clr ? 2'h0 : na + irq_a;
      nb <= clr ? 2'h0 : nb + irq_b;
      nx <= clr ? 2'h0 : nx + xi;
      if (chk) begin
         e = q.pop_front();
         checks_done++;
         if ((obs & e[45:23]) !== e[22:0]) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, obs & e[45:23], e[22:0]);
         end
      end
   end
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #(3000 * 40);
      miscompares++;
      finish_test();
   end
   initial begin
      {srst, clr} = 2'h3;
      {sr_rst, chk, sel, pins_in, st} = '0;
      pwr = pcd_pkg::PCD_RUN;
      wr = '0;
      {miscompares, checks_done, va, vb, vr} = {32'h0, 32'h0, 32'h5, 32'h1, 32'h3};
      void'($urandom(32'h1AFE));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      st <= 8'($urandom);
      pins_in <= 8'($urandom);
      exp(23'h183C00, {2'h0, pins_in[1], 1'b1, 19'h03000});
      wr_reg(4'h0, pcd_pkg::P3MODE_ADDR, 8'h02);
      repeat (8) @(posedge clk);
      exp(23'h180700, 23'h100500);
      $display("test reset and analog read done");
      wr_reg(pcd_pkg::CFG_BANK, pcd_pkg::CFG_ADDR, 8'h01);
      repeat (2) @(posedge clk);
      exp(23'h0038FF, {15'h0000, 1'b0, st[6:5], 1'b1, st[3:0]});
      wr_reg(pcd_pkg::CFG_BANK, pcd_pkg::CFG_ADDR, 8'hFE);
      repeat (2) @(posedge clk);
      exp(23'h0000FF, {15'h0000, st});
      $display("test pin routing done");
      irq_case(2'h0, 5, 5, 1, 5, 23'h008000);
      pwr <= pcd_pkg::PCD_HALT;
      irq_case(2'h2, 5, 1, 1, 1, 23'h040000);
      pwr <= pcd_pkg::PCD_RUN;
      irq_case(2'h1, 5, 5, 1, 5, 23'h008000);
      $display("test interrupts done");
      // Mode address in the wrong bank must be ignored
      wr_reg(pcd_pkg::CFG_BANK, pcd_pkg::P3MODE_ADDR, 8'h00);
      pwr <= pcd_pkg::PCD_STOP;
      repeat (2) @(posedge clk);
      exp(23'h004400, 23'h000400);
      sr_rst <= 1'b1;
      @(posedge clk);
      sr_rst <= 1'b0;
      pwr <= pcd_pkg::PCD_RUN;
      repeat (2) @(posedge clk);
      exp(23'h004400, 23'h004400);
      $display("test stop recovery done");
      wr_reg(4'h0, pcd_pkg::P3MODE_ADDR, 8'h01);
      irq_case(2'h0, 5, 5, 1, 1, 23'h200000);
      exp(23'h180C00, {2'h0, pins_in[1], 1'b1, 19'h00800});
      $display("test digital mode done");
      finish_test();
   end
endmodule : port_comparator_and_drain_control_tb_top

// ### verilog/pcd_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Mode bit 1 selects analog comparator inputs
// - Digital mode: reference pin is input, interrupt
// - Config D0 routes comparator results to pins
// - Comparator high when input above reference
// - Port read: bit1 comparator A, bit2 B
// - Routing drives A on pin4, B pin7
// - Stored pin bits kept, restored after routing
// - Bits 7:6 choose rising, falling, both edges
// - Both bits clear: B interrupts on fall
// - D7 set, D6 clear: both comparators interrupt
// - Analog mode: reference never interrupts
// - Pin1 timer input; comparator A in analog
// - Comparators and interrupts work during halt
// - Stop disables comparators; digital for recovery
// - Analog selection survives stop recovery reset
// - Mode D0 clear: port 2 open-drain
// - Config register at bank F address 00
// - Config D1: port 1 drive, default set
// - Config D2: port 0 drive, default set
module pcd_ctrl (
   input wire logic clk,
   input wire logic srst,
   input wire logic stop_recovery_rst,
   input wire pcd_pkg::pcd_power_e power_state,
   input wire pcd_pkg::pcd_wr_s wr,
   input wire logic [1:0] irq_edge_sel,
   input wire logic cmp_a_raw,
   input wire logic cmp_b_raw,
   input wire logic [7:0] p3_pins_in,
   input wire logic [7:0] p3_out_stored,
   output logic [7:0] p3_read,
   output logic [7:0] p3_pins_out,
   output logic cmp_enable,
   output logic analog_mode,
   output logic timer_in,
   output logic irq_cmp_a,
   output logic irq_cmp_b,
   output logic external_interrupt_one,
   output logic stop_sense_ok,
   output pcd_pkg::pcd_drive_s drive
);
   localparam int NCMP = 2;

   logic [7:0] mode_r;
   logic [7:0] mode_nxt;
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   logic [NCMP-1:0] raw_in;
   logic [NCMP-1:0] sync_q;
   logic [NCMP-1:0] fire;
   logic pref_r;
   logic pref_nxt;
   logic ref_fire;
   logic ana;
   logic route;
   logic [7:0] p3_read_nxt;
   logic [7:0] p3_pins_out_nxt;
   logic timer_in_nxt;
   logic irq_cmp_a_nxt;
   logic irq_cmp_b_nxt;
   logic ext_irq_nxt;

   function automatic logic edge_hit(input logic now, input logic prev, input logic [1:0] sel);
      logic rise;
      logic fall;
      rise = now & ~prev;
      fall = ~now & prev;
      unique case (sel)
         pcd_pkg::EDGE_RISE: edge_hit = rise;
         pcd_pkg::EDGE_BOTH: edge_hit = rise | fall;
         default: edge_hit = fall;
      endcase
   endfunction : edge_hit

   // Register writes; config writes are dropped while stop recovery holds
   always_comb begin
      mode_nxt = mode_r;
      cfg_nxt = cfg_r;
      if (wr.we && wr.addr == pcd_pkg::P3MODE_ADDR && wr.bank == 4'h0) begin
         mode_nxt = wr.wdata;
      end
      if (wr.we && wr.addr == pcd_pkg::CFG_ADDR && wr.bank == pcd_pkg::CFG_BANK
            && !stop_recovery_rst) begin
         cfg_nxt = wr.wdata;
      end
   end

   // Stop recovery resets leave mode untouched so analog survives
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_r <= pcd_pkg::P3MODE_RST;
         cfg_r <= pcd_pkg::CFG_RST;
      end else begin
         mode_r <= mode_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   assign ana = mode_r[pcd_pkg::MODE_ANA_BIT];
   assign route = cfg_r[pcd_pkg::CFG_ROUTE_BIT];
   assign analog_mode = ana;
   assign cmp_enable = ana && power_state != pcd_pkg::PCD_STOP;
   assign stop_sense_ok = ~ana;
   assign raw_in = {cmp_b_raw, cmp_a_raw};

   // Two-stage synchronisers; first stage read only by second
   for (genvar i = 0; i < NCMP; i++) begin : g_cmp
      logic [1:0] sync_r;
      logic [1:0] sync_nxt;
      logic prev_r;
      logic prev_nxt;
      always_comb begin
         sync_nxt = {sync_r[0], raw_in[i]};
         prev_nxt = sync_r[1];
      end
      always_ff @(posedge clk) begin
         if (srst) begin
            sync_r <= 2'h0;
            prev_r <= 1'b0;
         end else begin
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
         end
      end
      assign sync_q[i] = sync_r[1];
      // Edge gating uses the comparator path only while it is powered
      assign fire[i] = cmp_enable && edge_hit(sync_r[1], prev_r, irq_edge_sel);
   end

   always_comb begin
      pref_nxt = p3_pins_in[pcd_pkg::PIN_REF];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pref_r <= 1'b0;
      end else begin
         pref_r <= pref_nxt;
      end
   end

   // Reset value 0 means no false fall right after reset
   assign ref_fire = ~ana && ~p3_pins_in[pcd_pkg::PIN_REF] && pref_r;

   always_comb begin
      p3_read_nxt = p3_pins_in;
      if (ana) begin
         p3_read_nxt[pcd_pkg::RD_CMPA_BIT] = sync_q[0];
         p3_read_nxt[pcd_pkg::RD_CMPB_BIT] = sync_q[1];
      end
      p3_pins_out_nxt = p3_out_stored;
      if (route) begin
         p3_pins_out_nxt[pcd_pkg::PIN_CMPA_OUT] = sync_q[0];
         p3_pins_out_nxt[pcd_pkg::PIN_CMPB_OUT] = sync_q[1];
      end
      timer_in_nxt = ana ? sync_q[0] : p3_pins_in[pcd_pkg::PIN_APOS];
      irq_cmp_a_nxt = fire[0];
      irq_cmp_b_nxt = fire[1];
      ext_irq_nxt = ref_fire;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_cmp_a <= 1'b0;
         irq_cmp_b <= 1'b0;
         external_interrupt_one <= 1'b0;
         timer_in <= 1'b0;
         p3_read <= 8'h00;
         p3_pins_out <= 8'h00;
      end else begin
         irq_cmp_a <= irq_cmp_a_nxt;
         irq_cmp_b <= irq_cmp_b_nxt;
         external_interrupt_one <= ext_irq_nxt;
         timer_in <= timer_in_nxt;
         p3_read <= p3_read_nxt;
         p3_pins_out <= p3_pins_out_nxt;
      end
   end

   assign drive.p0_push_pull = cfg_r[pcd_pkg::CFG_P0PP_BIT];
   assign drive.p1_push_pull = cfg_r[pcd_pkg::CFG_P1PP_BIT];
   assign drive.p2_pull_up = mode_r[pcd_pkg::MODE_P2PU_BIT];

   route_pin4_a: assert property (
      @(posedge clk) disable iff (srst)
      route |=> p3_pins_out[pcd_pkg::PIN_CMPA_OUT] == $past(sync_q[0]))
      else $error("pin 4 not comparator A");

   route_pin7_a: assert property (
      @(posedge clk) disable iff (srst)
      route |=> p3_pins_out[pcd_pkg::PIN_CMPB_OUT] == $past(sync_q[1]))
      else $error("pin 7 not comparator B");

   restore_pin4_a: assert property (
      @(posedge clk) disable iff (srst)
      !route |=> p3_pins_out[4] == $past(p3_out_stored[4]))
      else $error("pin 4 not stored value");

   restore_pin7_a: assert property (
      @(posedge clk) disable iff (srst)
      !route |=> p3_pins_out[7] == $past(p3_out_stored[7]))
      else $error("pin 7 not stored value");

   other_pins_a: assert property (
      @(posedge clk) disable iff (srst)
      1'b1 |=> p3_pins_out[3:0] == $past(p3_out_stored[3:0]))
      else $error("unrouted pins disturbed");

   read_bit1_a: assert property (
      @(posedge clk) disable iff (srst)
      ana |=> p3_read[1] == $past(sync_q[0]))
      else $error("read bit 1 wrong");

   read_bit2_a: assert property (
      @(posedge clk) disable iff (srst)
      ana |=> p3_read[2] == $past(sync_q[1]))
      else $error("read bit 2 wrong");

   digital_read_a: assert property (
      @(posedge clk) disable iff (srst)
      !ana |=> p3_read[2:1] == $past(p3_pins_in[2:1]))
      else $error("digital read wrong");

   ref_read_a: assert property (
      @(posedge clk) disable iff (srst)
      1'b1 |=> p3_read[3] == $past(p3_pins_in[3]))
      else $error("reference read wrong");

   ref_quiet_a: assert property (
      @(posedge clk) disable iff (srst)
      ana |=> !external_interrupt_one)
      else $error("reference interrupted");

   ref_fall_a: assert property (
      @(posedge clk) disable iff (srst)
      !ana && pref_r && !p3_pins_in[pcd_pkg::PIN_REF] |=> external_interrupt_one)
      else $error("reference fall missed");

   ref_pulse_a: assert property (
      @(posedge clk) disable iff (srst)
      external_interrupt_one |=> !external_interrupt_one)
      else $error("reference interrupt too long");

   stop_off_a: assert property (
      @(posedge clk) disable iff (srst)
      power_state == pcd_pkg::PCD_STOP |-> !cmp_enable)
      else $error("comparators on in stop");

   sense_ok_a: assert property (
      @(posedge clk) disable iff (srst)
      1'b1 |-> stop_sense_ok != analog_mode)
      else $error("stop sensing flag wrong");

   halt_on_a: assert property (
      @(posedge clk) disable iff (srst)
      ana && power_state == pcd_pkg::PCD_HALT |-> cmp_enable)
      else $error("comparators off in halt");

   fall_irq_a: assert property (
      @(posedge clk) disable iff (srst)
      cmp_enable && irq_edge_sel == pcd_pkg::EDGE_FALL && $fell(sync_q[1]) |=> irq_cmp_b)
      else $error("missed fall");

   both_irq_a: assert property (
      @(posedge clk) disable iff (srst)
      cmp_enable && irq_edge_sel == pcd_pkg::EDGE_BOTH && $rose(sync_q[0]) |=> irq_cmp_a)
      else $error("missed rise on A");

   both_fall_a: assert property (
      @(posedge clk) disable iff (srst)
      cmp_enable && irq_edge_sel == pcd_pkg::EDGE_BOTH && $fell(sync_q[1]) |=> irq_cmp_b)
      else $error("missed fall on B");

   rise_irq_a: assert property (
      @(posedge clk) disable iff (srst)
      cmp_enable && irq_edge_sel == pcd_pkg::EDGE_RISE && $rose(sync_q[1]) |=> irq_cmp_b)
      else $error("missed rise on B");

   rise_only_a: assert property (
      @(posedge clk) disable iff (srst)
      cmp_enable && irq_edge_sel == pcd_pkg::EDGE_RISE && $fell(sync_q[0]) |=> !irq_cmp_a)
      else $error("fall fired in rise mode");

   quiet_irq_a: assert property (
      @(posedge clk) disable iff (srst)
      !cmp_enable |=> !irq_cmp_a && !irq_cmp_b)
      else $error("interrupt while disabled");

   keep_mode_a: assert property (
      @(posedge clk) disable iff (srst)
      stop_recovery_rst && !wr.we |=> mode_r == $past(mode_r))
      else $error("mode lost");

   keep_cfg_a: assert property (
      @(posedge clk) disable iff (srst)
      stop_recovery_rst |=> cfg_r == $past(cfg_r))
      else $error("config lost");

   timer_src_a: assert property (
      @(posedge clk) disable iff (srst)
      ana |=> timer_in == $past(sync_q[0]))
      else $error("timer source analog");

   timer_pin_a: assert property (
      @(posedge clk) disable iff (srst)
      !ana |=> timer_in == $past(p3_pins_in[pcd_pkg::PIN_APOS]))
      else $error("timer source digital");

   mode_wr_a: assert property (
      @(posedge clk) disable iff (srst)
      wr.we && wr.bank == 4'h0 && wr.addr == pcd_pkg::P3MODE_ADDR |=> mode_r == $past(wr.wdata))
      else $error("mode write lost");

   cfg_wr_a: assert property (
      @(posedge clk) disable iff (srst)
      wr.we && wr.bank == pcd_pkg::CFG_BANK && wr.addr == pcd_pkg::CFG_ADDR
         && !stop_recovery_rst |=> cfg_r == $past(wr.wdata))
      else $error("config write lost");

   drive_map_a: assert property (
      @(posedge clk) disable iff (srst)
      1'b1 |-> drive == {cfg_r[2], cfg_r[1], mode_r[0]})
      else $error("drive select wrong");
endmodule : pcd_ctrl

// ### verilog/pcd_pkg.sv
package pcd_pkg;
   // Register addresses: port configuration in expanded bank F, mode register in the standard file
   localparam logic [3:0] CFG_BANK = 4'hF;
   localparam logic [7:0] CFG_ADDR = 8'h00;
   localparam logic [7:0] P3MODE_ADDR = 8'hF7;
   localparam logic [7:0] P3_ADDR = 8'h03;
   // Field positions
   localparam int MODE_P2PU_BIT = 0;
   localparam int MODE_ANA_BIT = 1;
   localparam int CFG_ROUTE_BIT = 0;
   localparam int CFG_P1PP_BIT = 1;
   localparam int CFG_P0PP_BIT = 2;
   localparam int IRQ_SEL_LO_BIT = 6;
   localparam int IRQ_SEL_HI_BIT = 7;
   localparam int RD_CMPA_BIT = 1;
   localparam int RD_CMPB_BIT = 2;
   localparam int PIN_CMPA_OUT = 4;
   localparam int PIN_CMPB_OUT = 7;
   localparam int PIN_REF = 3;
   localparam int PIN_APOS = 1;
   localparam int PIN_BPOS = 2;
   // Reset values and edge select codes
   localparam logic [7:0] CFG_RST = 8'hFE;
   localparam logic [7:0] P3MODE_RST = 8'h00;
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [1:0] EDGE_RISE = 2'h1;

   typedef enum logic [2:0] {
      PCD_RUN = 3'h1,
      PCD_HALT = 3'h2,
      PCD_STOP = 3'h4
   } pcd_power_e;

   typedef struct packed {
      logic we;
      logic [3:0] bank;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcd_wr_s;

   typedef struct packed {
      logic p0_push_pull;
      logic p1_push_pull;
      logic p2_pull_up;
   } pcd_drive_s;
endpackage : pcd_pkg
